// >>> rtl/spw_pkg.sv
// Package of offsets, field layouts and constants for the protection bank
// Function
// - The source field holds the bus offset of the mode or chip select config register behind the latest violation.
// - Code bit value 1 is set when protection blocked a write to a protected register since the last status read.
// - Code bit value 2 is set on a software reset under protection, cleared by a status read or a mode, irq or select config write.
// - Code bit value 4 is set on a mode write while any select is active, or a select i config write while select i is active.
// - Coexisting conditions are reported as the sum of their values, from 3 up to 7.
// - Conditions accumulate between status reads and a status read clears them.
// - The capability register shows read-only presence flags for the optional features.
// - One flag says whether character length is configurable, and a field holds the fixed length when it is not.
// - Flags say whether phase and polarity are configurable, and companions give the fixed phase and polarity.
// - The lowest capability field gives the number of chip selects of this instance.
// - A read-only revision register holds a 12-bit version and a reserved field that steer nothing.
package spw_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int NUM_CS = 4;

    localparam logic [7:0] OFS_PROT_CTRL = 8'he4;
    localparam logic [7:0] OFS_PROT_STAT = 8'he8;
    localparam logic [7:0] OFS_CAPS = 8'hf8;
    localparam logic [7:0] OFS_REV = 8'hfc;
    localparam logic [7:0] OFS_MODE = 8'h04;
    localparam logic [7:0] OFS_CSR_BASE = 8'h30;
    localparam logic [7:0] OFS_CSR_STEP = 8'h04;

    localparam logic [23:0] PROT_KEY = 24'h535049;
    localparam int PROT_KEY_LSB = 8;
    localparam int PROT_EN_BIT = 0;
    localparam logic PROT_EN_RESET = 1'b0;

    localparam logic [2:0] CODE_BLOCKED = 3'h1;
    localparam logic [2:0] CODE_SWRST = 3'h2;
    localparam logic [2:0] CODE_LIVECFG = 3'h4;
    localparam logic [2:0] CODE_ALL = 3'h7;
    localparam int STAT_SRC_LSB = 8;
    localparam logic [2:0] CODE_RESET = 3'h0;
    localparam logic [7:0] SRC_RESET = 8'h00;

    localparam logic [31:0] CAPS_RESET = 32'h001f0154;
    localparam int CAP_SPUR_BIT = 20;
    localparam int CAP_RXFIFO_BIT = 19;
    localparam int CAP_BRIDGE_BIT = 18;
    localparam int CAP_SELREL_BIT = 17;
    localparam int CAP_EXTERNAL_DECODER_PRESENT_BIT = 16;
    localparam int CAP_FIXLEN_LSB = 9;
    localparam int CAP_CHAR_LENGTH_CONFIGURABLE_BIT = 8;
    localparam int CAP_PHZERO_BIT = 7;
    localparam int CAP_PHASE_CONFIGURABLE_BIT = 6;
    localparam int CAP_POLPOS_BIT = 5;
    localparam int CAP_POLCONF_BIT = 4;
    localparam logic [3:0] CAP_CS_COUNT = 4'h4;

    // Arbitrary neutral values, not a real part's revision
    localparam logic [11:0] REV_VERSION = 12'h101;
    localparam logic [3:0] REV_RESERVED = 4'h0;
    localparam int REV_RES_LSB = 16;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [ADDR_W-1:0] adr;
        logic [3:0] sel;
        logic [DATA_W-1:0] dat;
    } spw_wb_req_s;

    typedef struct packed {
        logic ack;
        logic [DATA_W-1:0] dat;
    } spw_wb_rsp_s;

    typedef struct packed {
        logic mode_wr;
        logic [NUM_CS-1:0] csr_wr;
        logic irq_en_wr;
        logic irq_dis_wr;
        logic sw_reset;
        logic [NUM_CS-1:0] cs_active;
    } spw_evt_s;
endpackage : spw_pkg

// >>> rtl/spw_regs.sv
// Protection status, capability and revision registers on classic Wishbone
//
// Implementation choice: the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none
module spw_regs
    import spw_pkg::*;
(
    // Clock, reset, enable
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic i_clk_en,
    // Register bus
    input wire spw_wb_req_s i_wb,
    output spw_wb_rsp_s o_wb,
    // Events from the transfer logic, same clock
    input wire spw_evt_s i_evt,
    // Protection state to the transfer logic
    output logic o_protect_en
);
    logic rst_meta_reg;
    logic rst_sync_reg;
    logic rst_n;

    logic ack_reg;
    logic ack_next;
    logic [DATA_W-1:0] rdat_reg;
    logic [DATA_W-1:0] rdat_next;
    logic prot_en_reg;
    logic prot_en_next;
    logic [2:0] code_reg;
    logic [2:0] code_next;
    logic [7:0] src_reg;
    logic [7:0] src_next;

    logic access;
    logic wr;
    logic rd;
    logic prot_wr;
    logic stat_rd;
    logic cfg_wr;
    logic unlock_wr;
    logic blocked;
    logic swrst_hit;
    logic live;
    logic [2:0] keep;
    logic [7:0] cfg_ofs;
    logic [7:0] csr_ofs [NUM_CS];
    logic [31:0] caps_word;
    logic [31:0] rev_word;

    // Release of reset through two stages; assertion stays asynchronous
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else if (i_clk_en) begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end
    assign rst_n = rst_sync_reg;

    // Holding off while ack is high drops ack the cycle after it was given
    assign access = i_wb.cyc & i_wb.stb & ~ack_reg;
    assign wr = access & i_wb.we;
    assign rd = access & ~i_wb.we;
    assign unlock_wr = (i_wb.dat[DATA_W-1:PROT_KEY_LSB] == PROT_KEY);
    assign prot_wr = wr & (i_wb.adr == OFS_PROT_CTRL) & (&i_wb.sel)
        & unlock_wr;
    assign stat_rd = rd & (i_wb.adr == OFS_PROT_STAT);

    generate
        for (genvar g = 0; g < NUM_CS; g++) begin : g_csr_ofs
            assign csr_ofs[g] = OFS_CSR_BASE + 8'(g * OFS_CSR_STEP);
        end
    endgenerate

    // Mode register wins the source field, then the lowest select
    always_comb begin
        cfg_ofs = SRC_RESET;
        for (int i = NUM_CS - 1; i >= 0; i--) begin
            if (i_evt.csr_wr[i]) begin
                cfg_ofs = csr_ofs[i];
            end
        end
        if (i_evt.mode_wr) begin
            cfg_ofs = OFS_MODE;
        end
    end

    assign cfg_wr = i_evt.mode_wr | (|i_evt.csr_wr);
    assign blocked = prot_en_reg & cfg_wr;
    assign swrst_hit = prot_en_reg & i_evt.sw_reset;
    assign live = (i_evt.mode_wr & (|i_evt.cs_active))
        | (|(i_evt.csr_wr & i_evt.cs_active));

    assign caps_word = {11'h000,
        CAPS_RESET[CAP_SPUR_BIT:CAP_EXTERNAL_DECODER_PRESENT_BIT],
        CAPS_RESET[15:CAP_FIXLEN_LSB],
        CAPS_RESET[CAP_CHAR_LENGTH_CONFIGURABLE_BIT],
        CAPS_RESET[CAP_PHZERO_BIT:CAP_POLCONF_BIT],
        CAP_CS_COUNT};
    assign rev_word = {12'h000, REV_RESERVED, 4'h0, REV_VERSION};

    // Status accumulation; a fresh event beats the clear of a read
    always_comb begin
        keep = stat_rd ? CODE_RESET : code_reg;
        code_next[0] = blocked | keep[0];
        code_next[1] = swrst_hit | (keep[1]
            & ~(cfg_wr | i_evt.irq_en_wr | i_evt.irq_dis_wr));
        code_next[2] = live | keep[2];
        src_next = stat_rd ? SRC_RESET : src_reg;
        if (blocked | live) begin
            src_next = cfg_ofs;
        end
        prot_en_next = prot_wr ? i_wb.dat[PROT_EN_BIT] : prot_en_reg;
    end

    // Bus answer; unmapped offsets and writes read back zero
    always_comb begin
        ack_next = access;
        rdat_next = '0;
        if (rd) begin
            case (i_wb.adr)
                OFS_PROT_CTRL: rdat_next = {31'h0, prot_en_reg};
                OFS_PROT_STAT: rdat_next = {16'h0, src_reg, 5'h00, code_reg};
                OFS_CAPS: rdat_next = caps_word;
                OFS_REV: rdat_next = rev_word;
                default: rdat_next = '0;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_reg <= 1'b0;
            rdat_reg <= '0;
            prot_en_reg <= PROT_EN_RESET;
            code_reg <= CODE_RESET;
            src_reg <= SRC_RESET;
        end else if (i_clk_en) begin
            ack_reg <= ack_next;
            rdat_reg <= rdat_next;
            prot_en_reg <= prot_en_next;
            code_reg <= code_next;
            src_reg <= src_next;
        end
    end

    assign o_wb.ack = ack_reg;
    assign o_wb.dat = rdat_reg;
    assign o_protect_en = prot_en_reg;

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!rst_n);

    sequence rd_caps_s;
        i_clk_en && rd && i_wb.adr == OFS_CAPS;
    endsequence
    sequence rd_rev_s;
        i_clk_en && rd && i_wb.adr == OFS_REV;
    endsequence
    sequence answer_s(logic [31:0] v);
        o_wb.ack && o_wb.dat == v;
    endsequence

    source_offset_a: assert property (
        i_clk_en && (blocked || live) |=> src_reg == $past(cfg_ofs))
        else $error("violation source not recorded");
    blocked_code_a: assert property (
        i_clk_en && prot_en_reg && i_evt.mode_wr |=> code_reg[0]
            && src_reg == OFS_MODE)
        else $error("blocked write not flagged");
    swrst_code_a: assert property (
        i_clk_en && prot_en_reg && i_evt.sw_reset |=> code_reg[1])
        else $error("protected reset not flagged");
    live_cfg_a: assert property (
        i_clk_en && |(i_evt.csr_wr & i_evt.cs_active) |=> code_reg[2])
        else $error("live select config write not flagged");
    code_sum_a: assert property (
        i_clk_en && blocked && swrst_hit && live |=> code_reg == CODE_ALL)
        else $error("combined code is not the sum");
    read_clear_a: assert property (
        i_clk_en && stat_rd && !blocked && !swrst_hit && !live
            |=> code_reg == CODE_RESET ##1 !o_wb.ack)
        else $error("status read did not clear");
    caps_value_a: assert property (
        rd_caps_s |=> answer_s(CAPS_RESET))
        else $error("capability word wrong");
    char_len_a: assert property (
        rd_caps_s |=> o_wb.dat[CAP_CHAR_LENGTH_CONFIGURABLE_BIT] == CAPS_RESET[CAP_CHAR_LENGTH_CONFIGURABLE_BIT])
        else $error("length flag wrong");
    phase_pol_a: assert property (
        rd_caps_s |=> o_wb.dat[7:4] == CAPS_RESET[CAP_PHZERO_BIT:CAP_POLCONF_BIT])
        else $error("phase or polarity flags wrong");
    cs_count_a: assert property (
        rd_caps_s |=> o_wb.dat[3:0] == CAP_CS_COUNT)
        else $error("select count wrong");
    rev_value_a: assert property (
        rd_rev_s |=> answer_s(rev_word) && o_wb.dat[11:0] == REV_VERSION)
        else $error("revision word wrong");
    key_gate_a: assert property (
        i_clk_en && wr && i_wb.adr == OFS_PROT_CTRL && !unlock_wr
            |=> $stable(prot_en_reg))
        else $error("enable changed without key");
    ro_write_a: assert property (
        i_clk_en && wr && (i_wb.adr == OFS_CAPS || i_wb.adr == OFS_REV)
            |=> $stable(prot_en_reg) && o_wb.ack && o_wb.dat == '0)
        else $error("read-only write had an effect");

    // Further steps of status and control behaviour
    sequence ctrl_wr_s;
        i_clk_en && wr && i_wb.adr == OFS_PROT_CTRL;
    endsequence
    sequence stat_rd_s;
        i_clk_en && stat_rd;
    endsequence
    sequence quiet_s;
        i_clk_en && !blocked && !live;
    endsequence

    // Bus handshake shape, not tied to a rule
    ack_pulse_a: assert property (
        i_clk_en && o_wb.ack |=> !o_wb.ack)
        else $error("ack held for two cycles");
    idle_data_a: assert property (
        i_clk_en && !rd |=> o_wb.dat == '0)
        else $error("read data not zero outside a read");
    // Low enable must freeze every register of the bank
    freeze_state_a: assert property (
        !i_clk_en |=> $stable(code_reg) && $stable(src_reg)
            && $stable(prot_en_reg) && $stable(ack_reg))
        else $error("state moved while enable low");
    key_set_a: assert property (
        ctrl_wr_s and (unlock_wr && (&i_wb.sel) && i_wb.dat[PROT_EN_BIT])
            |=> prot_en_reg)
        else $error("keyed enable not taken");
    key_clear_a: assert property (
        ctrl_wr_s and (unlock_wr && (&i_wb.sel) && !i_wb.dat[PROT_EN_BIT])
            |=> !prot_en_reg)
        else $error("keyed disable not taken");
    sel_gate_a: assert property (
        ctrl_wr_s and !(&i_wb.sel) |=> $stable(prot_en_reg))
        else $error("partial control write changed enable");
    stat_layout_a: assert property (
        stat_rd_s |=> o_wb.ack && o_wb.dat[DATA_W-1:16] == '0
            && o_wb.dat[7:3] == '0)
        else $error("status word has stray bits");
    blocked_csr_a: assert property (
        i_clk_en && prot_en_reg && (|i_evt.csr_wr) |=> code_reg[0])
        else $error("blocked select config write not flagged");
    // Without protection nothing can be blocked
    no_block_a: assert property (
        i_clk_en && !prot_en_reg && !code_reg[0] |=> !code_reg[0])
        else $error("blocked flag set while unprotected");
    no_swrst_a: assert property (
        i_clk_en && !prot_en_reg && !code_reg[1] |=> !code_reg[1])
        else $error("reset flag set while unprotected");
    swrst_clear_a: assert property (
        i_clk_en && !swrst_hit
            && (cfg_wr || i_evt.irq_en_wr || i_evt.irq_dis_wr)
            |=> !code_reg[1])
        else $error("reset flag survived a config write");
    live_mode_a: assert property (
        i_clk_en && i_evt.mode_wr && (|i_evt.cs_active)
            |=> code_reg[2] && src_reg == OFS_MODE)
        else $error("live mode write not flagged");
    idle_select_a: assert property (
        i_clk_en && !code_reg[2] && !(|i_evt.cs_active) |=> !code_reg[2])
        else $error("live flag set with no select active");
    code_hold_a: assert property (
        quiet_s and !stat_rd |=> $stable(code_reg[0]) && $stable(code_reg[2]))
        else $error("status bits changed with no event");
    src_hold_a: assert property (
        quiet_s and !stat_rd |=> $stable(src_reg))
        else $error("source changed with no violation");
    src_clear_a: assert property (
        stat_rd_s and !blocked && !live |=> src_reg == SRC_RESET)
        else $error("source not cleared by read");
    rev_unused_a: assert property (
        rd_rev_s |=> o_wb.dat[DATA_W-1:20] == '0 && o_wb.dat[15:12] == '0
            && o_wb.dat[19:16] == REV_RESERVED)
        else $error("revision unused bits not zero");
    caps_unused_a: assert property (
        rd_caps_s |=> o_wb.dat[DATA_W-1:21] == '0)
        else $error("capability unused bits not zero");
    caps_flags_a: assert property (
        rd_caps_s |=> o_wb.dat[CAP_SPUR_BIT:CAP_EXTERNAL_DECODER_PRESENT_BIT]
            == CAPS_RESET[CAP_SPUR_BIT:CAP_EXTERNAL_DECODER_PRESENT_BIT])
        else $error("presence flags wrong");
    fixed_len_a: assert property (
        rd_caps_s |=> o_wb.dat[15:CAP_FIXLEN_LSB]
            == CAPS_RESET[15:CAP_FIXLEN_LSB])
        else $error("fixed length field wrong");
endmodule : spw_regs
`default_nettype wire

// >>> dv/spw_tb.sv
// Self-checking bench for the protection status and capability bank
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import spw_pkg::*;
    logic i_sys_clk;
    logic i_rst_b;
    logic i_clk_en;
    spw_wb_req_s wb;
    spw_wb_rsp_s rsp;
    spw_evt_s evt;
    spw_evt_s e;
    logic prot;
    logic [3:0] cs;
    logic [32:0] note;
    logic [32:0] notes[$];
    int miscompares;
    int n_tests;
    int cycles;

    spw_regs u_spw_regs (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
        .i_clk_en(i_clk_en), .i_wb(wb), .o_wb(rsp), .i_evt(evt),
        .o_protect_en(prot));

    initial begin
        i_sys_clk = 1'b0;
        forever #20 i_sys_clk = ~i_sys_clk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string msg);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH at %0t: %s got %h exp %h", $time, msg, got,
                     exp);
        end
    endtask : check

    task automatic close_out;
        $display("%0d checks, %0d miscompares", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : close_out

    // Note goes in before the request, so the monitor never sees an orphan
    task automatic bus(input logic we, input logic [7:0] adr,
                       input logic [31:0] dat, input logic [32:0] exp);
        notes.push_back(exp);
        @(posedge i_sys_clk);
        wb.cyc <= 1'b1;
        wb.stb <= 1'b1;
        wb.we <= we;
        wb.adr <= adr;
        wb.sel <= 4'hf;
        wb.dat <= dat;
        do @(posedge i_sys_clk); while (rsp.ack !== 1'b1);
        wb <= '0;
    endtask : bus

    task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
        bus(1'b0, adr, 32'h0, {1'b1, exp});
    endtask : rd

    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        bus(1'b1, adr, dat, 33'h0);
    endtask : wr

    task automatic pulse(input spw_evt_s ev);
        @(posedge i_sys_clk);
        evt <= ev;
        @(posedge i_sys_clk);
        evt <= '0;
    endtask : pulse

    always @(posedge i_sys_clk) begin
        cycles <= cycles + 1;
        if (rsp.ack === 1'b1) begin
            if (notes.size() == 0) begin
                check(32'h1, 32'h0, "ack without request");
            end else begin
                note = notes.pop_front();
                if (note[32]) check(rsp.dat, note[31:0], "read data");
            end
        end
        // Whole run needs about a hundred and ten cycles
        if (cycles == 3000) begin
            miscompares++;
            close_out();
        end
    end

    initial begin
        i_rst_b = 1'b0;
        i_clk_en = 1'b1;
        wb = '0;
        evt = '0;
        miscompares = 0;
        n_tests = 0;
        cycles = 0;
        void'($urandom(32'h978d203b));
        repeat (2) @(posedge i_sys_clk);
        i_rst_b <= 1'b1;
        repeat (3) @(posedge i_sys_clk);
        rd(OFS_CAPS, 32'h001f0154);
        wr(OFS_CAPS, $urandom());
        wr(OFS_REV, $urandom());
        rd(OFS_CAPS, 32'h001f0154);
        rd(OFS_REV, {12'h0, REV_RESERVED, 4'h0, REV_VERSION});
        rd(8'h80, 32'h0);
        $display("test identity done");
        wr(OFS_PROT_CTRL, 32'h53504801);
        rd(OFS_PROT_CTRL, 32'h0);
        wr(OFS_PROT_CTRL, {PROT_KEY, 8'h01});
        rd(OFS_PROT_CTRL, 32'h1);
        check({31'h0, prot}, 32'h1, "protect level");
        $display("test key done");
        e = '0;
        e.mode_wr = 1'b1;
        pulse(e);
        rd(OFS_PROT_STAT, {16'h0, OFS_MODE, 8'h01});
        rd(OFS_PROT_STAT, 32'h0);
        for (int k = 0; k < 2; k++) begin
            e = '0;
            e.sw_reset = 1'b1;
            pulse(e);
            if (k == 0) rd(OFS_PROT_STAT, 32'h2);
            if (k == 1) pulse(e);
            e = '0;
            e.irq_en_wr = (k == 0);
            e.irq_dis_wr = (k == 1);
            pulse(e);
            rd(OFS_PROT_STAT, 32'h0);
        end
        $display("test reset code done");
        // Set beats clear: reset and select write in one cycle keep code 2
        for (int i = 0; i < NUM_CS; i++) begin
            cs = 4'($urandom());
            e = '0;
            e.sw_reset = 1'b1;
            e.csr_wr[i] = 1'b1;
            e.cs_active = cs;
            pulse(e);
            rd(OFS_PROT_STAT, {16'h0, OFS_CSR_BASE + 8'(i * 4), 5'h0,
                               cs[i], 2'h3});
        end
        e = '0;
        e.mode_wr = 1'b1;
        e.cs_active = 4'h8;
        pulse(e);
        rd(OFS_PROT_STAT, {16'h0, OFS_MODE, 8'h05});
        $display("test combined done");
        wr(OFS_PROT_CTRL, {PROT_KEY, 8'h00});
        rd(OFS_PROT_CTRL, 32'h0);
        e.csr_wr = 4'h2;
        e.cs_active = 4'h2;
        pulse(e);
        rd(OFS_PROT_STAT, {16'h0, OFS_MODE, 8'h04});
        rd(OFS_PROT_STAT, 32'h0);
        $display("test live config done");
        // Events while enable is low must leave no trace
        i_clk_en <= 1'b0;
        e = '0;
        e.mode_wr = 1'b1;
        e.cs_active = 4'h1;
        pulse(e);
        i_clk_en <= 1'b1;
        rd(OFS_PROT_STAT, 32'h0);
        $display("test freeze done");
        repeat (2) @(posedge i_sys_clk);
        close_out();
    end
endmodule : testbench
`default_nettype wire
